// file: hdl/rpc_pkg.sv
package rpc_pkg;

	// Register bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register byte offsets
	localparam logic [7:0] OFF_CACHE_PERIOD = 8'hb4;
	localparam logic [7:0] OFF_TIMER_STATUS = 8'hb8;
	localparam logic [7:0] OFF_PREFETCH_CTRL = 8'hbc;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'hd0;
	localparam logic [7:0] OFF_IRQ_MASK = 8'hd4;

	// Reset values
	localparam logic [31:0] RST_CACHE_PERIOD = 32'h0000_0040;
	localparam logic [31:0] RST_TIMER_STATUS = 32'h0000_0000;
	localparam logic [31:0] RST_PREFETCH_CTRL = 32'h0300_0041;
	localparam logic [2:0] RST_IRQ = 3'h0;

	// Prefetch control field positions
	localparam int PLAIN_SEL_BIT = 26;
	localparam int LINE_SEL_BIT = 25;
	localparam int MULTI_SEL_BIT = 24;
	localparam int LINE_FAST_LSB = 18;
	localparam int LINE_SLOW_LSB = 12;
	localparam int MULTI_FAST_LSB = 6;
	localparam int MULTI_SLOW_LSB = 0;
	localparam int LIMIT_W = 6;
	localparam logic [31:0] PREFETCH_WMASK = 32'h07ff_ffff;

	// Timer status and interrupt bit positions
	localparam int RETRY_BIT = 0;
	localparam int HOLD_BIT = 1;
	localparam int DISCARD_BIT = 2;
	localparam int IRQ_W = 3;

	// Prefetch amounts in bytes
	localparam int BYTES_W = 13;
	localparam int CHUNK_SHIFT = 6;
	localparam logic [12:0] DWORD_BYTES = 13'h0004;
	localparam logic [12:0] CACHE_LINE_BYTES = 13'h0040;

	// Read commands seen on the secondary bus
	typedef enum logic [1:0] {
		CMD_PLAIN,
		CMD_LINE,
		CMD_MULTI,
		CMD_OTHER
	} rpc_cmd_e;

	// Hold timer states
	typedef enum logic {
		HOLD_IDLE,
		HOLD_COUNT
	} rpc_hold_e;

endpackage

// file: hdl/rpc_hold_timer.sv
`timescale 1ns/100ps
module rpc_hold_timer (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic ce,
	// Control
	input wire logic start,
	input wire logic cancel,
	input wire logic [31:0] period,
	// Status
	output logic active,
	output logic expire
);
	import rpc_pkg::*;

	rpc_hold_e state;
	rpc_hold_e next_state;
	logic [31:0] remain;
	logic [31:0] next_remain;
	logic next_expire;

	// Countdown of cycles left before cached data is dropped
	always_comb begin
		next_state = state;
		next_remain = remain;
		next_expire = 1'b0;
		case (state)
			HOLD_IDLE: begin
				if (start) begin
					next_state = HOLD_COUNT;
					next_remain = period;
				end
			end
			HOLD_COUNT: begin
				if (start) begin
					next_remain = period; // Fresh fill restarts the window
				end else if (cancel) begin
					next_state = HOLD_IDLE;
				end else if (remain <= 32'h0000_0001) begin
					next_state = HOLD_IDLE; // R1
					next_expire = 1'b1;
				end else begin
					next_remain = remain - 32'h0000_0001;
				end
			end
			default: begin
				next_state = HOLD_IDLE;
			end
		endcase
	end

	// Timer registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= HOLD_IDLE;
			remain <= 32'h0000_0000;
			expire <= 1'b0;
		end else if (ce) begin
			state <= next_state;
			remain <= next_remain;
			expire <= next_expire;
		end
	end

	assign active = (state == HOLD_COUNT);

endmodule

// file: hdl/rpc_prefetch_ctrl.sv
// Added by the designer: strobed register access.
`timescale 1ns/100ps
// Function
// R1: Drop short-term cached data after the programmed count of clock cycles.
// R2: Timer status bit 2 reads one while the discard timer is expired.
// R3: Timer status bit 0 reads one while the retry timer is expired.
// R4: Plain read fetches one dword, or the line limit when bit 26 set.
// R5: Line read fetches one cacheline, or the line limit when bit 25 set.
// R6: Multiple read fetches two cachelines, or multi limit when bit 24 set.
// R7: Limit fields count 64-byte chunks, zero meaning 64 bytes.
// R8: Line limit for fast bus sits in bits 23:18, reset zero.
// R9: Line limit for slow bus sits in bits 17:12, reset zero.
// R10: Multi limit for fast bus sits in bits 11:6, reset one.
// R11: Multi limit for slow bus sits in bits 5:0, reset one.
// R12: Fast or slow limit follows the current secondary bus speed.
module rpc_prefetch_ctrl (
	// Clock, reset and enable
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic ce,
	// Register port
	input wire logic [rpc_pkg::ADDR_W-1:0] regAddr,
	input wire logic [rpc_pkg::DATA_W-1:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [rpc_pkg::DATA_W-1:0] regRdata,
	// Secondary bus state
	input wire logic busFast,
	input wire logic discardTimerIn,
	input wire logic retryTimerIn,
	// Read request from a bus master
	input wire logic reqValid,
	input wire rpc_pkg::rpc_cmd_e reqCmd,
	output logic grantValid,
	output logic [rpc_pkg::BYTES_W-1:0] grantBytes,
	// Short-term cache
	input wire logic cacheFill,
	input wire logic cacheTaken,
	output logic cacheValid,
	output logic cacheDiscard,
	// Interrupt
	output logic irq
);
	import rpc_pkg::*;

	logic [31:0] cache_hold_cycles;
	logic [31:0] next_cache_hold_cycles;
	logic [31:0] prefetchCtrl;
	logic [31:0] next_prefetchCtrl;
	logic [IRQ_W-1:0] irqStatus;
	logic [IRQ_W-1:0] next_irqStatus;
	logic [IRQ_W-1:0] irqMask;
	logic [IRQ_W-1:0] next_irqMask;
	logic [31:0] next_regRdata;
	logic next_irq;

	logic discard_timer_expired;
	logic retry_timer_expired;
	logic discardPrev;
	logic retryPrev;
	logic [IRQ_W-1:0] events;

	logic plain_read_prefetch_sel;
	logic line_read_prefetch_sel;
	logic multi_read_prefetch_sel;
	logic [LIMIT_W-1:0] line_read_limit_fast;
	logic [LIMIT_W-1:0] line_read_limit_slow;
	logic [LIMIT_W-1:0] multi_read_limit_fast;
	logic [LIMIT_W-1:0] multi_read_limit_slow;
	logic [LIMIT_W-1:0] lineLimit;
	logic [LIMIT_W-1:0] multiLimit;
	logic [BYTES_W-1:0] lineLimitBytes;
	logic [BYTES_W-1:0] multiLimitBytes;
	logic next_grantValid;
	logic [BYTES_W-1:0] next_grantBytes;

	logic holdActive;
	logic holdExpire;
	logic next_cacheValid;
	logic next_cacheDiscard;

	// Field views of the prefetch control register
	assign plain_read_prefetch_sel = prefetchCtrl[PLAIN_SEL_BIT];
	assign line_read_prefetch_sel = prefetchCtrl[LINE_SEL_BIT];
	assign multi_read_prefetch_sel = prefetchCtrl[MULTI_SEL_BIT];
	assign line_read_limit_fast =
		prefetchCtrl[LINE_FAST_LSB +: LIMIT_W]; // R8
	assign line_read_limit_slow =
		prefetchCtrl[LINE_SLOW_LSB +: LIMIT_W]; // R9
	assign multi_read_limit_fast =
		prefetchCtrl[MULTI_FAST_LSB +: LIMIT_W]; // R10
	assign multi_read_limit_slow =
		prefetchCtrl[MULTI_SLOW_LSB +: LIMIT_W]; // R11

	// Pick the limit set matching the current bus speed
	assign lineLimit = busFast ? line_read_limit_fast
		: line_read_limit_slow; // R12
	assign multiLimit = busFast ? multi_read_limit_fast
		: multi_read_limit_slow; // R12

	// Chunk count to bytes: (field + 1) * 64
	assign lineLimitBytes =
		BYTES_W'({1'b0, lineLimit} + 7'h01) << CHUNK_SHIFT; // R7
	assign multiLimitBytes =
		BYTES_W'({1'b0, multiLimit} + 7'h01) << CHUNK_SHIFT; // R7

	// Live expiry levels of the external timers
	assign discard_timer_expired = discardTimerIn; // R2
	assign retry_timer_expired = retryTimerIn; // R3

	// Rising edges of the timers and a cache drop raise events
	always_comb begin
		events = '0;
		events[RETRY_BIT] = retryTimerIn && !retryPrev;
		events[DISCARD_BIT] = discardTimerIn && !discardPrev;
		events[HOLD_BIT] = holdExpire;
	end

	// Prefetch amount decided per command
	always_comb begin
		next_grantValid = 1'b0;
		next_grantBytes = grantBytes;
		if (reqValid) begin
			case (reqCmd)
				CMD_PLAIN: begin
					next_grantValid = 1'b1;
					next_grantBytes = plain_read_prefetch_sel
						? lineLimitBytes : DWORD_BYTES; // R4
				end
				CMD_LINE: begin
					next_grantValid = 1'b1;
					next_grantBytes = line_read_prefetch_sel
						? lineLimitBytes : CACHE_LINE_BYTES; // R5
				end
				CMD_MULTI: begin
					next_grantValid = 1'b1;
					next_grantBytes = multi_read_prefetch_sel
						? multiLimitBytes
						: BYTES_W'(CACHE_LINE_BYTES << 1); // R6
				end
				default: begin
					next_grantValid = 1'b0;
				end
			endcase
		end
	end

	// Short-term cache hold window
	rpc_hold_timer u_hold (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.ce(ce),
		.start(cacheFill),
		.cancel(cacheTaken),
		.period(cache_hold_cycles),
		.active(holdActive),
		.expire(holdExpire)
	);

	// Cache outputs follow the hold timer
	always_comb begin
		next_cacheValid = holdActive; // R1
		next_cacheDiscard = holdExpire; // R1
	end

	// Register writes, sticky status and read data
	always_comb begin
		next_cache_hold_cycles = cache_hold_cycles;
		next_prefetchCtrl = prefetchCtrl;
		next_irqMask = irqMask;
		next_irqStatus = irqStatus;
		next_regRdata = 32'h0000_0000;
		if (regWr) begin
			case (regAddr)
				OFF_CACHE_PERIOD: begin
					next_cache_hold_cycles = regWdata; // R1
				end
				OFF_PREFETCH_CTRL: begin
					next_prefetchCtrl = regWdata & PREFETCH_WMASK;
				end
				OFF_IRQ_STATUS: begin
					next_irqStatus = irqStatus & ~regWdata[IRQ_W-1:0];
				end
				OFF_IRQ_MASK: begin
					next_irqMask = regWdata[IRQ_W-1:0];
				end
				default: begin
					next_irqMask = irqMask; // Unmapped writes ignored
				end
			endcase
		end
		// New events win over a clear in the same cycle
		next_irqStatus = next_irqStatus | events;
		if (regRd) begin
			case (regAddr)
				OFF_CACHE_PERIOD: begin
					next_regRdata = cache_hold_cycles;
				end
				OFF_TIMER_STATUS: begin
					next_regRdata[DISCARD_BIT] =
						discard_timer_expired; // R2
					next_regRdata[RETRY_BIT] = retry_timer_expired; // R3
				end
				OFF_PREFETCH_CTRL: begin
					next_regRdata = prefetchCtrl;
				end
				OFF_IRQ_STATUS: begin
					next_regRdata[IRQ_W-1:0] = irqStatus;
				end
				OFF_IRQ_MASK: begin
					next_regRdata[IRQ_W-1:0] = irqMask;
				end
				default: begin
					next_regRdata = 32'h0000_0000;
				end
			endcase
		end
		next_irq = |(next_irqStatus & next_irqMask);
	end

	// State registers, frozen while the enable is low
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cache_hold_cycles <= RST_CACHE_PERIOD; // R1
			prefetchCtrl <= RST_PREFETCH_CTRL; // R8
			irqStatus <= RST_IRQ;
			irqMask <= RST_IRQ;
			regRdata <= 32'h0000_0000;
			irq <= 1'b0;
			discardPrev <= 1'b0;
			retryPrev <= 1'b0;
			grantValid <= 1'b0;
			grantBytes <= '0;
			cacheValid <= 1'b0;
			cacheDiscard <= 1'b0;
		end else if (ce) begin
			cache_hold_cycles <= next_cache_hold_cycles;
			prefetchCtrl <= next_prefetchCtrl;
			irqStatus <= next_irqStatus;
			irqMask <= next_irqMask;
			regRdata <= next_regRdata;
			irq <= next_irq;
			discardPrev <= discardTimerIn;
			retryPrev <= retryTimerIn;
			grantValid <= next_grantValid;
			grantBytes <= next_grantBytes;
			cacheValid <= next_cacheValid;
			cacheDiscard <= next_cacheDiscard;
		end
	end

endmodule

// file: bench/rpc_props.sv
`timescale 1ns/100ps
module rpc_props (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic ce,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic regRd,
	input wire logic [31:0] regRdata,
	input wire logic discardTimerIn,
	input wire logic retryTimerIn,
	// Requests and cache
	input wire logic reqValid,
	input wire rpc_pkg::rpc_cmd_e reqCmd,
	input wire logic grantValid,
	input wire logic [12:0] grantBytes,
	input wire logic cacheFill,
	input wire logic cacheValid,
	input wire logic cacheDiscard
);
	import rpc_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// A read request that the block must answer
	sequence reqTaken;
		ce && reqValid && reqCmd != CMD_OTHER;
	endsequence
	// Status register read with live timer levels
	sequence statusRead;
		ce && regRd && regAddr == OFF_TIMER_STATUS;
	endsequence
	a_grant_follow: assert property (reqTaken |=> grantValid)
		else $error("grant missing after request");
	a_grant_refuse: assert property (
		ce && !(reqValid && reqCmd != CMD_OTHER) |=> !grantValid)
		else $error("grant without request");
	a_grant_chunks: assert property (grantValid |->
		grantBytes == 13'h0004 || (grantBytes[5:0] == 6'h00 &&
		grantBytes != 13'h0000 && grantBytes <= 13'h1000))
		else $error("grant size not in 64 byte units");
	a_bytes_hold: assert property (!grantValid |-> $stable(grantBytes))
		else $error("grant size changed without grant");
	a_discard_flag: assert property (
		statusRead |=> regRdata[2] == $past(discardTimerIn))
		else $error("discard flag wrong");
	a_retry_flag: assert property (statusRead |=>
		regRdata[0] == $past(retryTimerIn) &&
		regRdata[31:3] == 29'h0000_0000 && !regRdata[1])
		else $error("retry flag wrong");
	a_drop_once: assert property (cacheDiscard |=> !cacheDiscard)
		else $error("discard longer than one cycle");
	a_drop_clears: assert property (cacheDiscard |-> !cacheValid)
		else $error("cache valid during discard");
	a_valid_start: assert property ($rose(cacheValid) |->
		$past(cacheFill, 2))
		else $error("cache valid without fill");
endmodule
bind rpc_prefetch_ctrl rpc_props chk_u (
	.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .regAddr(regAddr),
	.regRd(regRd), .regRdata(regRdata), .discardTimerIn(discardTimerIn),
	.retryTimerIn(retryTimerIn), .reqValid(reqValid), .reqCmd(reqCmd),
	.grantValid(grantValid), .grantBytes(grantBytes),
	.cacheFill(cacheFill), .cacheValid(cacheValid),
	.cacheDiscard(cacheDiscard)
);

// file: bench/rpc_pci_master.sv
`timescale 1ns/100ps
module rpc_pci_master (
	// Clock
	input wire logic ref_clk,
	// Read request
	output logic reqValid,
	output rpc_pkg::rpc_cmd_e reqCmd
);
	import rpc_pkg::*;
	// Idle bus at start
	initial begin
		reqValid = 1'b0;
		reqCmd = CMD_OTHER;
	end
	// One-cycle request, after gap idle cycles for a slow master
	task automatic issue(input rpc_cmd_e cmd, input int gap);
		repeat (gap) @(posedge ref_clk);
		@(posedge ref_clk);
		reqValid <= 1'b1;
		reqCmd <= cmd;
		@(posedge ref_clk);
		reqValid <= 1'b0;
		reqCmd <= rpc_cmd_e'(~cmd); // Released lines do not keep the command
	endtask
endmodule

// file: bench/read_prefetch_and_cache_ctrl_bench.sv
`timescale 1ns/100ps
module read_prefetch_and_cache_ctrl_bench;
	import rpc_pkg::*;
	typedef struct {
		logic [31:0] ctrl;
		logic fast;
		rpc_cmd_e cmd;
		logic [12:0] bytes;
	} rpc_row_s;
	logic ref_clk = 1'b0, rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0;
	logic busFast = 1'b0, discardTimerIn = 1'b0, retryTimerIn = 1'b0;
	logic cacheFill = 1'b0, cacheTaken = 1'b0, ce = 1'b1;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWdata = 32'h0, regRdata, v;
	logic reqValid, grantValid, cacheValid, cacheDiscard, irq;
	logic [12:0] grantBytes;
	rpc_cmd_e reqCmd;
	int mismatches = 0, cmp_count = 0, n;
	// Command table: control word, bus speed, command, expected size
	rpc_row_s rows [13] = '{
		'{32'h0300_0041, 1'b0, CMD_PLAIN, 13'h0004},
		'{32'h0300_0041, 1'b0, CMD_LINE, 13'h0040},
		'{32'h0300_0041, 1'b1, CMD_MULTI, 13'h0080},
		'{32'h0300_0041, 1'b0, CMD_OTHER, 13'h0000},
		'{32'h07fc_217f, 1'b1, CMD_PLAIN, 13'h1000},
		'{32'h07fc_217f, 1'b0, CMD_PLAIN, 13'h00c0},
		'{32'h07fc_217f, 1'b0, CMD_LINE, 13'h00c0},
		'{32'h07fc_217f, 1'b1, CMD_LINE, 13'h1000},
		'{32'h07fc_217f, 1'b1, CMD_MULTI, 13'h0180},
		'{32'h07fc_217f, 1'b0, CMD_MULTI, 13'h1000},
		'{32'h00fc_217f, 1'b1, CMD_LINE, 13'h0040},
		'{32'h00fc_217f, 1'b1, CMD_MULTI, 13'h0080},
		'{32'h00fc_217f, 1'b1, CMD_PLAIN, 13'h0004}
	};
	logic [7:0] offs [5] = '{OFF_CACHE_PERIOD, OFF_TIMER_STATUS,
		OFF_PREFETCH_CTRL, OFF_IRQ_STATUS, 8'h00};
	logic [31:0] rstv [5] = '{RST_CACHE_PERIOD, RST_TIMER_STATUS,
		RST_PREFETCH_CTRL, 32'h0, 32'h0};
	// Design and bus master
	rpc_prefetch_ctrl dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .busFast(busFast), .discardTimerIn(discardTimerIn),
		.retryTimerIn(retryTimerIn), .reqValid(reqValid), .reqCmd(reqCmd),
		.grantValid(grantValid), .grantBytes(grantBytes), .cacheFill(cacheFill),
		.cacheTaken(cacheTaken), .cacheValid(cacheValid),
		.cacheDiscard(cacheDiscard), .irq(irq));
	rpc_pci_master mst_u (.ref_clk(ref_clk), .reqValid(reqValid),
		.reqCmd(reqCmd));
	// 125 MHz clock
	always #4 ref_clk = ~ref_clk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1;
		d = regRdata;
	endtask
	// Fill the cache, optionally consume it, count cycles to discard
	task automatic hold(input logic take, input int expN);
		@(posedge ref_clk) cacheFill <= 1'b1;
		@(posedge ref_clk) cacheFill <= 1'b0;
		for (n = 1; n <= 80; n++) begin
			@(posedge ref_clk) cacheTaken <= take && n == 1;
			#1;
			if (n == 1) chk(cacheValid, 1'b1);
			if (cacheDiscard === 1'b1) break;
		end
		chk(n, expN);
	endtask
	task automatic report_and_stop;
		$display("Checks %0d, mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		foreach (rows[i]) begin
			wr(OFF_PREFETCH_CTRL, rows[i].ctrl);
			busFast <= rows[i].fast;
			mst_u.issue(rows[i].cmd, i % 2);
			#1;
			chk(grantValid, rows[i].cmd != CMD_OTHER);
			if (rows[i].bytes != 0) chk(grantBytes, rows[i].bytes);
		end
		$display("Command table done");
		wr(OFF_CACHE_PERIOD, 32'h0000_0009);
		@(posedge ref_clk) rst_n <= 1'b0;
		@(posedge ref_clk) rst_n <= 1'b1;
		foreach (offs[i]) begin
			rd(offs[i], v);
			chk(v, rstv[i]);
		end
		wr(OFF_PREFETCH_CTRL, 32'hffff_ffff);
		wr(OFF_TIMER_STATUS, 32'hffff_ffff);
		rd(OFF_PREFETCH_CTRL, v);
		chk(v, 32'h07ff_ffff);
		rd(OFF_TIMER_STATUS, v);
		chk(v, 32'h0);
		$display("Reset and access done");
		@(posedge ref_clk) discardTimerIn <= 1'b1;
		rd(OFF_TIMER_STATUS, v);
		chk(v, 32'h4);
		chk(irq, 1'b0);
		wr(OFF_IRQ_MASK, 32'h4);
		@(posedge ref_clk) {discardTimerIn, retryTimerIn} <= 2'b01;
		rd(OFF_TIMER_STATUS, v);
		chk(v, 32'h1);
		chk(irq, 1'b1);
		rd(OFF_IRQ_STATUS, v);
		chk(v, 32'h5);
		wr(OFF_IRQ_STATUS, 32'h4);
		rd(OFF_IRQ_STATUS, v);
		chk(v, 32'h1);
		chk(irq, 1'b0);
		$display("Timer status done");
		hold(1'b0, 65);
		rd(OFF_IRQ_STATUS, v);
		chk(v, 32'h3);
		wr(OFF_CACHE_PERIOD, 32'h0000_0003);
		hold(1'b0, 4);
		hold(1'b1, 81);
		$display("Cache hold done");
		// Enable low must swallow a request, enable high must answer it
		@(posedge ref_clk) ce <= 1'b0;
		mst_u.issue(CMD_PLAIN, 0);
		#1;
		chk(grantValid, 1'b0);
		@(posedge ref_clk) ce <= 1'b1;
		mst_u.issue(CMD_PLAIN, 0);
		#1;
		chk(grantValid, 1'b1);
		chk(grantBytes, 13'h1000);
		$display("Enable done");
		report_and_stop();
	end
endmodule
